// *** src/mdp_params.svh ***
// Purpose: Constants for the matrix shutdown and dither PWM block
// Assumes: Register indices are word indices, byte address is 4x index
// Notes: Included by the design file and the testbench
`ifndef MDP_PARAMS_SVH
`define MDP_PARAMS_SVH
`define MDP_IDX_CFG 10'h060
`define MDP_IDX_PULL 10'h062
`define MDP_IDX_STAT 10'h070
`define MDP_IDX_UPD 10'h0FD
`define MDP_IDX_PWM0 10'h001
`define MDP_UPD_KEY 8'h00
`define MDP_CFG_RST 3'h0
`define MDP_PULL_RST 2'h3
`define MDP_CFG_SSD 0
`define MDP_CFG_MODE_LO 1
`define MDP_CFG_MODE_HI 2
`define MDP_MODE_84 2'h2
`define MDP_MAX6 8'h3F
`define MDP_MAX8 8'hFF
`define MDP_DMAX2 4'h3
`define MDP_DMAX4 4'hF
`endif

// *** src/mdp_pkg.sv ***
// Purpose: Types shared by the matrix shutdown and dither PWM block
// Assumes: Nothing beyond the params header
// Notes: Power states are Gray coded along run, soft and hard
package mdp_pkg;
    typedef enum logic [1:0]
    {
        MDP_RUN = 2'h0,
        MDP_SOFT = 2'h1,
        MDP_HARD = 2'h3
    } mdp_pwr_t;
endpackage

// *** src/mdp_top.sv ***
// Purpose: Shutdown control, dithered PWM and pull gating for an LED matrix
// Assumes: APB slave, 32-bit data, one 100 MHz clock, sync active-high reset
// Notes: Pending PWM words go live only through the update register
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "mdp_params.svh"

// Notes on behaviour
// - Pulls enabled only on outputs that are off
// - Registers keep values through either shutdown
// - Soft shutdown bit written 0 enters shutdown
// - Soft shutdown turns all sinks off
// - Bus access works during soft shutdown
// - Low shutdown pin disables all analog drive
// - Pin back high resumes normal operation
// - Bus access works during hardware shutdown
// - Low mode: 6-bit period, 8-bit resolution
// - Low mode: 4-period cycle, 2 dither bits
// - High mode: 8-bit period, 12-bit resolution
// - High mode: 16-period cycle, 4 dither bits
// - Resolution field 00 selects 6+2 mode
// - Resolution field 10 selects 8+4 mode
// - Zero write to update copies pending PWM; here only while the pin is high and the soft shutdown bit is 1
module mdp_top #(
    parameter int NCS = 18,
    parameter int NSW = 12,
    parameter int PWM_DIV = 1
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Shutdown pin, active low
    input wire logic shutdown_pin_n_i,
    // Matrix outputs
    output logic [NSW-1:0] scan_switch_outputs_o,
    output logic [NSW-1:0] sw_pull_down_en_o,
    output logic [NCS-1:0] current_sink_outputs_o,
    output logic [NCS-1:0] cs_pull_up_en_o
);
    localparam int DW = (PWM_DIV > 1) ? $clog2(PWM_DIV) : 1;

    // Whole module state
    typedef struct packed {
        logic [2:0] cfg;
        logic [1:0] pull;
        logic [NCS-1:0][11:0] pend;
        logic [NCS-1:0][11:0] act;
        mdp_pkg::mdp_pwr_t pwr;
        logic [DW-1:0] div;
        logic [7:0] cnt;
        logic [3:0] dcnt;
        logic [NSW-1:0] sw;
        logic [NSW-1:0] swo;
        logic [NCS-1:0] cs;
        logic [NSW-1:0] swpd;
        logic [NCS-1:0] cspu;
        logic [31:0] rdata;
        logic err;
    } mdp_state_t;

    mdp_state_t s_r;
    mdp_state_t s_nxt;
    logic [9:0] idx;
    logic wr_acc;
    logic setup;
    logic tick;
    logic m84;
    logic wrap;
    logic [7:0] cmax;
    logic [3:0] dmax;

    // Decode helpers
    assign idx = paddr_i[11:2];
    assign setup = psel_i & ~penable_i;
    assign wr_acc = psel_i & penable_i & pwrite_i;
    assign m84 = (s_r.cfg[`MDP_CFG_MODE_HI:`MDP_CFG_MODE_LO] == `MDP_MODE_84);
    assign cmax = m84 ? `MDP_MAX8 : `MDP_MAX6;
    assign dmax = m84 ? `MDP_DMAX4 : `MDP_DMAX2;
    assign tick = (PWM_DIV <= 1) || (s_r.div == DW'(PWM_DIV - 1));
    assign wrap = tick && (s_r.cnt >= cmax); // Also recovers when the mode shrinks mid-period

    // Zero-wait slave; read data was latched in setup
    assign pready_o = 1'b1;
    assign prdata_o = s_r.rdata;
    assign pslverr_o = s_r.err;
    assign scan_switch_outputs_o = s_r.swo;
    assign current_sink_outputs_o = s_r.cs;
    assign sw_pull_down_en_o = s_r.swpd;
    assign cs_pull_up_en_o = s_r.cspu;

    // Bit reversal spreads the extra steps over the cycle
    function automatic logic extra_step(input logic [3:0] d, input logic [3:0] lo,
                                        input logic hi);
        logic [3:0] r;
        r = hi ? {d[0], d[1], d[2], d[3]} : {2'h0, d[0], d[1]};
        extra_step = (r < lo);
    endfunction

    // Next-state logic
    always_comb
    begin
        logic [8:0] lim;
        logic [3:0] lo;
        logic on;
        logic run;
        lim = 9'h000;
        lo = 4'h0;
        on = 1'b0;
        s_nxt = s_r;
        s_nxt.err = 1'b0;
        run = (s_r.pwr == mdp_pkg::MDP_RUN);
        // Power state follows pin first, then soft bit
        if (!shutdown_pin_n_i)
        begin
            s_nxt.pwr = mdp_pkg::MDP_HARD;
        end
        else if (!s_r.cfg[`MDP_CFG_SSD])
        begin
            s_nxt.pwr = mdp_pkg::MDP_SOFT;
        end
        else
        begin
            s_nxt.pwr = mdp_pkg::MDP_RUN;
        end
        // Register access ignores power state, except that update copies only when awake
        if (setup)
        begin
            s_nxt.rdata = 32'h0000_0000;
            if (idx == `MDP_IDX_CFG)
            begin
                s_nxt.rdata[2:0] = s_r.cfg;
            end
            else if (idx == `MDP_IDX_PULL)
            begin
                s_nxt.rdata[1:0] = s_r.pull;
            end
            else if (idx == `MDP_IDX_STAT)
            begin
                s_nxt.rdata[7:0] = {s_r.dcnt, 1'b0, m84, s_r.pwr};
            end
            else if (idx == `MDP_IDX_UPD)
            begin
                s_nxt.rdata = 32'h0000_0000;
            end
            else if (idx >= `MDP_IDX_PWM0 && idx < `MDP_IDX_PWM0 + 10'(NCS))
            begin
                s_nxt.rdata[11:0] = s_r.pend[idx - `MDP_IDX_PWM0];
            end
            else
            begin
                s_nxt.err = 1'b1;
            end
        end
        else if (wr_acc)
        begin
            s_nxt.err = s_r.err;
            if (idx == `MDP_IDX_CFG)
            begin
                s_nxt.cfg = pwdata_i[2:0];
            end
            else if (idx == `MDP_IDX_PULL)
            begin
                s_nxt.pull = pwdata_i[1:0];
            end
            else if (idx == `MDP_IDX_UPD)
            begin
                // Update only when fully awake and key matches
                if (pwdata_i[7:0] == `MDP_UPD_KEY && shutdown_pin_n_i
                    && s_r.cfg[`MDP_CFG_SSD])
                begin
                    s_nxt.act = s_r.pend;
                end
            end
            else if (idx >= `MDP_IDX_PWM0 && idx < `MDP_IDX_PWM0 + 10'(NCS))
            begin
                s_nxt.pend[idx - `MDP_IDX_PWM0] = pwdata_i[11:0];
            end
        end
        else if (psel_i)
        begin
            s_nxt.err = s_r.err;
        end
        // Step enable divider
        s_nxt.div = tick ? '0 : DW'(s_r.div + 1'b1);
        // Period and dither counters
        if (tick)
        begin
            s_nxt.cnt = wrap ? 8'h00 : 8'(s_r.cnt + 8'h01);
        end
        if (wrap)
        begin
            s_nxt.dcnt = (s_r.dcnt >= dmax) ? 4'h0 : 4'(s_r.dcnt + 4'h1);
            s_nxt.sw = {s_r.sw[NSW-2:0], s_r.sw[NSW-1]};
        end
        // Switch drive blanked outside run, on the same edge that registers the power decision
        s_nxt.swo = (s_nxt.pwr == mdp_pkg::MDP_RUN) ? s_nxt.sw : '0;
        // Sink compare with per-period extra step
        for (int i = 0; i < NCS; i++)
        begin
            if (m84)
            begin
                lo = s_r.act[i][3:0];
                lim = {1'b0, s_r.act[i][11:4]};
            end
            else
            begin
                lo = {2'h0, s_r.act[i][1:0]};
                lim = {3'h0, s_r.act[i][7:2]};
            end
            lim = 9'(lim + {8'h00, extra_step(s_r.dcnt, lo, m84)});
            on = ({1'b0, s_r.cnt} < lim);
            s_nxt.cs[i] = on && run;
            // Pull-up only on an idle sink and with analog alive
            s_nxt.cspu[i] = !(on && run) && s_r.pull[1]
                            && shutdown_pin_n_i;
        end
        // Pull-down judged on the drive value it is registered beside, so no overlap
        for (int j = 0; j < NSW; j++)
        begin
            s_nxt.swpd[j] = !s_nxt.swo[j] && s_r.pull[0]
                            && shutdown_pin_n_i;
        end
    end

    // State register; shutdown never touches register contents
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            s_r <= '0;
            s_r.cfg <= `MDP_CFG_RST;
            s_r.pull <= `MDP_PULL_RST;
            s_r.pwr <= mdp_pkg::MDP_HARD;
            s_r.sw <= NSW'(1);
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence hard_req;
        !shutdown_pin_n_i;
    endsequence
    sequence awake2;
        (shutdown_pin_n_i && s_r.cfg[`MDP_CFG_SSD])[*2];
    endsequence

    a_pull_idle_cs: assert property ((s_r.cs & s_r.cspu) == '0)
        else $error("sink pull-up on while sink drives");
    a_pull_idle_sw: assert property ((s_r.swo & s_r.swpd) == '0)
        else $error("switch pull-down on while switch drives");
    a_hard_blank: assert property (hard_req |=> s_r.cspu == '0 ##1 s_r.cs == '0)
        else $error("outputs alive in hardware shutdown");
    a_soft_blank: assert property (!s_r.cfg[`MDP_CFG_SSD] |=> ##1 s_r.cs == '0)
        else $error("sinks alive in soft shutdown");
    a_regs_kept: assert property (!psel_i && s_r.pwr != mdp_pkg::MDP_RUN
        |=> $stable(s_r.pend) && $stable(s_r.cfg) && $stable(s_r.act))
        else $error("register changed in shutdown");
    a_cfg_written: assert property (wr_acc && idx == `MDP_IDX_CFG
        |=> s_r.cfg == $past(pwdata_i[2:0]))
        else $error("config write lost");
    a_pend_written: assert property (wr_acc && idx == `MDP_IDX_PWM0
        |=> s_r.pend[0] == $past(pwdata_i[11:0]))
        else $error("pwm write lost");
    a_update_copy: assert property (wr_acc && idx == `MDP_IDX_UPD
        && pwdata_i[7:0] == `MDP_UPD_KEY && s_r.cfg[`MDP_CFG_SSD]
        && shutdown_pin_n_i |=> s_r.act == $past(s_r.pend))
        else $error("update did not copy");
    a_update_block: assert property (wr_acc && idx == `MDP_IDX_UPD
        && !shutdown_pin_n_i |=> $stable(s_r.act))
        else $error("update taken in shutdown");
    a_enter_soft: assert property (shutdown_pin_n_i && !s_r.cfg[`MDP_CFG_SSD]
        |=> s_r.pwr == mdp_pkg::MDP_SOFT)
        else $error("soft shutdown not entered");
    a_resume_run: assert property (awake2 |-> s_r.pwr == mdp_pkg::MDP_RUN)
        else $error("no resume after pin high");
    a_period_six: assert property (!m84 && wrap |=> s_r.cnt == 8'h00)
        else $error("6-bit period wrong");
    a_dither_four: assert property (!m84 && wrap && s_r.dcnt == `MDP_DMAX2
        && $stable(s_r.cfg) |=> s_r.dcnt == 4'h0)
        else $error("4-period dither cycle wrong");
    a_period_eight: assert property (m84 && tick && s_r.cnt == `MDP_MAX6
        |=> s_r.cnt == 8'h40)
        else $error("8-bit period wrapped early");
    a_dither_sixteen: assert property (m84 && wrap && s_r.dcnt == 4'h3
        && $stable(s_r.cfg) |=> s_r.dcnt == 4'h4)
        else $error("16-period dither cycle wrong");
    a_mode_zero: assert property (s_r.cfg[`MDP_CFG_MODE_HI:`MDP_CFG_MODE_LO] == 2'h0
        |-> !m84)
        else $error("field 00 not 6+2 mode");
endmodule // mdp_top

// *** verification/mdp_led_model.sv ***
// Purpose: LED matrix model on the scan switches and current sinks
// Assumes: Matrix outputs registered on core_clk_i, high means conducting
// Notes: Counts sink 0 only; pull flags stay set until the end of the run
`timescale 1ns/1ps
module mdp_led_model #(
    parameter int NCS = 18,
    parameter int NSW = 12
) (
    // Clock and counter clear
    input wire logic core_clk_i,
    input wire logic clr_i,
    // Matrix side
    input wire logic [NSW-1:0] sw_i,
    input wire logic [NSW-1:0] sw_pd_i,
    input wire logic [NCS-1:0] cs_i,
    input wire logic [NCS-1:0] cs_pu_i,
    // Observations
    output int lit_cnt_o,
    output int step_cnt_o,
    output logic ghost_o,
    output logic pull_seen_o
);
    logic [NSW-1:0] sw_prev;
    initial
    begin
        ghost_o = 1'b0;
        pull_seen_o = 1'b0;
    end
    // A pull on a conducting pin burns power, so it is flagged for good
    always @(posedge core_clk_i)
    begin
        sw_prev <= sw_i;
        if (((sw_i & sw_pd_i) != 0) || ((cs_i & cs_pu_i) != 0))
            ghost_o <= 1'b1;
        if (cs_pu_i[0] === 1'b1)
            pull_seen_o <= 1'b1;
        if (clr_i)
        begin
            lit_cnt_o <= 0;
            step_cnt_o <= 0;
        end
        else
        begin
            lit_cnt_o <= lit_cnt_o + int'(cs_i[0] === 1'b1);
            step_cnt_o <= step_cnt_o + int'(sw_i !== sw_prev);
        end
    end
endmodule // mdp_led_model

// *** verification/tb_top.sv ***
// Purpose: Self-checking bench for shutdown, dither PWM and pull gating
// Assumes: APB master with zero-wait slave, byte address is 4x index
// Notes: Each scenario is one task; windows span whole dither cycles, save the 64-cycle window after reset and the 256-cycle shutdown windows
`timescale 1ns/1ps
`include "mdp_params.svh"
module tb_top;
    localparam logic [11:0] A_CFG = {`MDP_IDX_CFG, 2'b00};
    localparam logic [11:0] A_PULL = {`MDP_IDX_PULL, 2'b00};
    localparam logic [11:0] A_STAT = {`MDP_IDX_STAT, 2'b00};
    localparam logic [11:0] A_UPD = {`MDP_IDX_UPD, 2'b00};
    localparam logic [11:0] A_PWM0 = {`MDP_IDX_PWM0, 2'b00};
    localparam logic [11:0] A_PWM1 = {`MDP_IDX_PWM0 + 10'h001, 2'b00};
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic pin_n = 1'b1;
    logic clr = 1'b0;
    logic [11:0] sw, swpd;
    logic [17:0] cs, cspu;
    int lit, steps, error_cnt, n_compared;
    logic ghost, pull_seen;
    // Zero-wait slave, so a transfer is two cycles
    mdp_top uut (.core_clk_i(core_clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .shutdown_pin_n_i(pin_n),
        .scan_switch_outputs_o(sw), .sw_pull_down_en_o(swpd),
        .current_sink_outputs_o(cs), .cs_pull_up_en_o(cspu));
    mdp_led_model led (.core_clk_i(core_clk), .clr_i(clr), .sw_i(sw), .sw_pd_i(swpd),
        .cs_i(cs), .cs_pu_i(cspu), .lit_cnt_o(lit), .step_cnt_o(steps), .ghost_o(ghost),
        .pull_seen_o(pull_seen));
    initial
    begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic er);
        int k;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        // Answer taken at the edge itself, before the design updates anything
        @(posedge core_clk);
        k = 1;
        while (pready !== 1'b1 && k < 16)
        begin
            @(posedge core_clk);
            k++;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            error_cnt++;
            final_report();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
    endtask
    task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] m,
        input logic [31:0] exp);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 32'h0, rd, er);
        chk(what, exp, rd & m);
    endtask
    // Settle, clear, then count sink 0 and switch steps over n cycles
    task automatic meas(input int n, input int e_lit, input int e_steps);
        repeat (4) @(posedge core_clk);
        clr <= 1'b1;
        @(posedge core_clk);
        clr <= 1'b0;
        repeat (n) @(posedge core_clk);
        #1;
        chk("lit cycles", e_lit, lit);
        chk("switch steps", e_steps, steps);
    endtask
    task automatic t_reset();
        logic [31:0] rd;
        logic er;
        rdc("cfg", A_CFG, 32'hFFFFFFFF, 32'h0);
        rdc("stat", A_STAT, 32'h7, 32'h1);
        rdc("pull", A_PULL, 32'hFFFFFFFF, 32'h3);
        meas(64, 0, 0);
        apb(1'b0, 12'hFFC, 32'h0, rd, er);
        chk("unmapped data", 32'h0, rd);
        chk("unmapped err", 32'h1, er);
        $display("test reset done");
    endtask
    task automatic t_low();
        wr(A_PWM0, 32'h0B);
        wr(A_CFG, 32'h1);
        wr(A_UPD, 32'h0);
        meas(256, 11, 4);
        wr(A_PWM0, 32'h3F);
        wr(A_UPD, 32'h1);
        meas(256, 11, 4);
        wr(A_UPD, 32'h0);
        meas(256, 63, 4);
        $display("test low mode done");
    endtask
    task automatic t_high();
        wr(A_PWM0, 32'h235);
        wr(A_CFG, 32'h5);
        wr(A_UPD, 32'h0);
        rdc("stat mode", A_STAT, 32'h7, 32'h4);
        meas(4096, 565, 16);
        $display("test high mode done");
    endtask
    task automatic t_soft();
        wr(A_CFG, 32'h4);
        rdc("stat soft", A_STAT, 32'h3, 32'h1);
        meas(256, 0, 0);
        wr(A_PULL, 32'h1);
        rdc("pull soft", A_PULL, 32'hFFFFFFFF, 32'h1);
        rdc("pwm soft", A_PWM0, 32'hFFF, 32'h235);
        wr(A_CFG, 32'h5);
        wr(A_PULL, 32'h3);
        $display("test soft shutdown done");
    endtask
    task automatic t_hard();
        @(posedge core_clk);
        pin_n <= 1'b0;
        rdc("stat hard", A_STAT, 32'h3, 32'h3);
        meas(256, 0, 0);
        chk("pulls hard", 32'h0, {cspu, swpd});
        wr(A_PWM1, 32'h7);
        rdc("pwm hard", A_PWM1, 32'hFFF, 32'h7);
        rdc("cfg hard", A_CFG, 32'hFFFFFFFF, 32'h5);
        wr(A_UPD, 32'h0);
        // Host restores its registers before raising the pin
        wr(A_PWM0, 32'h235);
        wr(A_CFG, 32'h5);
        wr(A_PULL, 32'h3);
        @(posedge core_clk);
        pin_n <= 1'b1;
        rdc("stat back", A_STAT, 32'h3, 32'h0);
        meas(4096, 565, 16);
        chk("pull gating", 32'h0, ghost);
        chk("pull used", 32'h1, pull_seen);
        $display("test hard shutdown done");
    endtask
    // Reset for ten cycles, then the scenarios in order
    initial
    begin
        error_cnt = 0;
        n_compared = 0;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_low();
        t_high();
        t_soft();
        t_hard();
        final_report();
    end
endmodule // tb_top
